// ---- src/qrw_flash_host.sv ----
`timescale 1ns/1ps
module qrw_flash_host (
	// System
	input wire logic clk,
	input wire logic sys_rst,
	// AXI4-Lite slave
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Link
	qrw_link_if.host link
);
	import qrw_pkg::*;

	logic awDone_r;
	logic wDone_r;
	logic [4:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic [31:0] wMask;
	logic write_enable_cmd;
	logic [31:0] cmd_r;
	logic [31:0] tx_r;
	logic [31:0] rx_r;
	logic [31:0] cmdMerged;
	qrw_host_state_t hst_r;
	qrw_phase_t ph_r;
	logic [3:0] half_r;
	logic [4:0] gap_r;
	logic [8:0] left_r;
	logic [39:0] txSh_r;
	logic [3:0] ioA_r;
	logic [3:0] ioB_r;
	logic tick;
	logic busy;

	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : gLane
			assign wMask[gb*8+7:gb*8] = {8{wStrb_r[gb]}};
		end
	endgenerate

	assign write_enable_cmd = awDone_r && wDone_r && !s_axi_bvalid;
	assign cmdMerged = (cmd_r & ~wMask) | (wData_r & wMask);
	assign busy = hst_r != HS_IDLE;
	assign tick = half_r == HALF_PERIOD_LAST;

	// Write channels, taken in either order
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			awDone_r <= 1'b0;
			wDone_r <= 1'b0;
			awAddr_r <= 5'h0;
			wData_r <= 32'h0;
			wStrb_r <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awDone_r <= 1'b1;
				awAddr_r <= s_axi_awaddr[4:0];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wDone_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (write_enable_cmd) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awAddr_r == REG_CMD || awAddr_r == REG_TX ||
					awAddr_r == REG_RX || awAddr_r == REG_STATUS) ?
					RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				awDone_r <= 1'b0;
				wDone_r <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (s_axi_araddr[4:0])
				REG_CMD: s_axi_rdata <= cmd_r;
				REG_TX: s_axi_rdata <= tx_r;
				REG_RX: s_axi_rdata <= rx_r;
				REG_STATUS: s_axi_rdata <= {31'h0, busy};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_r <= 32'h0;
		end else if (write_enable_cmd && awAddr_r == REG_TX) begin
			tx_r <= (tx_r & ~wMask) | (wData_r & wMask);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ioA_r <= 4'hF;
			ioB_r <= 4'hF;
		end else begin
			ioA_r <= link.io;
			ioB_r <= ioA_r;
		end
	end

	// Serial clock divider and transfer sequencer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hst_r <= HS_IDLE;
			ph_r <= PH_OPC;
			cmd_r <= 32'h0;
			half_r <= 4'h0;
			gap_r <= 5'h0;
			left_r <= 9'h0;
			txSh_r <= 40'h0;
			rx_r <= 32'h0;
			link.csN <= 1'b1;
			link.sclk <= 1'b0;
		end else begin
			half_r <= (hst_r == HS_RUN && !tick) ? half_r + 4'h1 : 4'h0;
			case (hst_r)
				HS_IDLE: begin
					if (write_enable_cmd && awAddr_r == REG_CMD) begin
						cmd_r <= cmdMerged;
						hst_r <= HS_RUN;
						link.csN <= 1'b0;
						if (cmdMerged[CMD_SKIP_BIT]) begin
							txSh_r <= {tx_r, 8'h00};
							ph_r <= cmdMerged[CMD_QUAD_BIT] ? PH_QAD : PH_SER;
							left_r <= cmdMerged[CMD_QUAD_BIT] ? 9'h8 :
								{3'h0, cmdMerged[CMD_LEN_LSB +: 3], 3'h0};
						end else begin
							txSh_r <= {cmdMerged[7:0], tx_r};
							ph_r <= PH_OPC;
							left_r <= 9'h8;
						end
					end
				end
				HS_RUN: begin
					if (tick && !link.sclk) begin
						link.sclk <= 1'b1;
						left_r <= left_r - 9'h1;
						if (ph_r == PH_RX) begin
							rx_r <= {rx_r[27:0], ioB_r};
						end
					end else if (tick || left_r == 9'h0) begin
						link.sclk <= 1'b0;
						if (ph_r == PH_QAD) begin
							txSh_r <= {txSh_r[35:0], 4'h0};
						end else begin
							txSh_r <= {txSh_r[38:0], 1'b0};
						end
						if (left_r == 9'h0) begin
							hst_r <= HS_GAP;
							link.csN <= 1'b1;
							if (ph_r == PH_OPC && cmd_r[CMD_QUAD_BIT]) begin
								hst_r <= HS_RUN;
								link.csN <= 1'b0;
								ph_r <= PH_QAD;
								left_r <= 9'h8;
							end else if (ph_r == PH_OPC &&
								cmd_r[CMD_LEN_LSB +: 3] != 3'h0) begin
								hst_r <= HS_RUN;
								link.csN <= 1'b0;
								ph_r <= PH_SER;
								left_r <= {3'h0, cmd_r[CMD_LEN_LSB +: 3], 3'h0};
							end else if (ph_r == PH_QAD) begin
								hst_r <= HS_RUN;
								link.csN <= 1'b0;
								ph_r <= PH_DUM;
								left_r <= 9'h4;
							end else if (ph_r == PH_DUM &&
								cmd_r[CMD_RXN_LSB +: 8] != 8'h0) begin
								hst_r <= HS_RUN;
								link.csN <= 1'b0;
								ph_r <= PH_RX;
								left_r <= {cmd_r[CMD_RXN_LSB +: 8], 1'b0};
							end
						end
					end
				end
				HS_GAP: begin
					gap_r <= gap_r + 5'h1;
					if (gap_r == CS_GAP_LAST) begin
						gap_r <= 5'h0;
						hst_r <= HS_IDLE;
					end
				end
				default: hst_r <= HS_IDLE;
			endcase
		end
	end

	// Lane drive follows the phase one cycle later
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			link.hostIo <= 4'hF;
			link.hostIoOeN <= 4'hF;
		end else if (hst_r == HS_RUN && ph_r == PH_QAD) begin
			link.hostIo <= txSh_r[39:36];
			link.hostIoOeN <= 4'h0;
		end else if (hst_r == HS_RUN && (ph_r == PH_OPC || ph_r == PH_SER)) begin
			link.hostIo <= {3'h7, txSh_r[39]};
			link.hostIoOeN <= 4'hE;
		end else begin
			link.hostIo <= 4'hF;
			link.hostIoOeN <= 4'hF;
		end
	end
endmodule // qrw_flash_host

// ---- src/qrw_pkg.sv ----
package qrw_pkg;
	// Clock and array
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned ADDR_W = 20;
	localparam int unsigned MEM_IDX_W = 6;
	localparam int unsigned MEM_BYTES = 64;
	localparam logic [7:0] MEM_RESET = 8'h00;
	localparam logic [7:0] MEM_ERASED = 8'hFF;

	// Opcodes and continuous mode key
	localparam logic [7:0] OPC_QUAD_IO_READ = 8'hEB;
	localparam logic [7:0] OPC_SET_WRAP = 8'h77;
	localparam logic [7:0] OPC_PAGE_ERASE = 8'h81;
	localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OPC_HALF_BLOCK_ERASE = 8'h52;
	localparam logic [7:0] OPC_BLOCK_ERASE = 8'hD8;
	localparam logic [7:0] OPC_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OPC_CHIP_ERASE_B = 8'hC7;
	localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
	localparam logic [1:0] CONT_MODE_KEY = 2'h2;

	// Link phase counts (last index within a phase, or total bits), synchroniser idle value and wrap reset
	localparam logic [5:0] OPC_LAST = 6'h07;
	localparam logic [5:0] QADDR_LAST = 6'h05;
	localparam logic [5:0] QMODE_LAST = 6'h01;
	localparam logic [5:0] QDUMMY_LAST = 6'h03;
	localparam logic [5:0] BITS_SHORT = 6'h08;
	localparam logic [5:0] BITS_ADDR = 6'h20;
	localparam logic [5:0] BITS_WRAP = 6'h28;
	localparam logic [5:0] SYNC_IDLE = 6'h2F;
	localparam logic [2:0] WRAP_RESET = 3'h7;

	// Self-timed erase durations
	localparam int unsigned PAGE_ERASE_TIME_US = 8000;
	localparam int unsigned SECTOR_ERASE_TIME_US = 40000;
	localparam int unsigned HALF_BLOCK_ERASE_TIME_US = 120000;
	localparam int unsigned BLOCK_ERASE_TIME_US = 150000;
	localparam int unsigned WHOLE_ARRAY_ERASE_TIME_US = 3000000;
	localparam int unsigned PAGE_ERASE_CYCLES = PAGE_ERASE_TIME_US * CLK_MHZ;
	localparam int unsigned SECTOR_ERASE_CYCLES =
		SECTOR_ERASE_TIME_US * CLK_MHZ;
	localparam int unsigned HALF_BLOCK_ERASE_CYCLES =
		HALF_BLOCK_ERASE_TIME_US * CLK_MHZ;
	localparam int unsigned BLOCK_ERASE_CYCLES = BLOCK_ERASE_TIME_US * CLK_MHZ;
	localparam int unsigned WHOLE_ARRAY_ERASE_CYCLES =
		WHOLE_ARRAY_ERASE_TIME_US * CLK_MHZ;

	// Host link timing
	localparam logic [3:0] HALF_PERIOD_LAST = 4'h7;
	localparam logic [4:0] CS_GAP_LAST = 5'h0F;

	// Host registers
	localparam logic [4:0] REG_CMD = 5'h00;
	localparam logic [4:0] REG_TX = 5'h04;
	localparam logic [4:0] REG_RX = 5'h08;
	localparam logic [4:0] REG_STATUS = 5'h0C;
	localparam int unsigned CMD_QUAD_BIT = 8;
	localparam int unsigned CMD_SKIP_BIT = 9;
	localparam int unsigned CMD_LEN_LSB = 10;
	localparam int unsigned CMD_RXN_LSB = 13;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum {DS_IDLE, DS_OPC, DS_QADDR, DS_QMODE, DS_QDUMMY, DS_QDATA,
		DS_SER, DS_SKIP} qrw_dev_state_t;
	typedef enum {HS_IDLE, HS_RUN, HS_GAP} qrw_host_state_t;
	typedef enum {PH_OPC, PH_SER, PH_QAD, PH_DUM, PH_RX} qrw_phase_t;
endpackage

// ---- src/qrw_link_if.sv ----
`timescale 1ns/1ps
interface qrw_link_if;
	logic csN;
	logic sclk;
	logic [3:0] hostIo;
	logic [3:0] hostIoOeN;
	logic [3:0] devIo;
	logic [3:0] devIoOeN;
	logic [3:0] io;

	// Undriven lanes float high as with pull-ups
	assign io = (~hostIoOeN & hostIo) | (~devIoOeN & devIo) |
		(hostIoOeN & devIoOeN);

	modport host(output csN, output sclk, output hostIo, output hostIoOeN,
		input io);
	modport dev(input csN, input sclk, input io, output devIo,
		output devIoOeN);
endinterface

// ---- src/qrw_flash_dev.sv ----
`timescale 1ns/1ps
module qrw_flash_dev #(
	parameter int unsigned PAGE_CYCLES = qrw_pkg::PAGE_ERASE_CYCLES,
	parameter int unsigned SECTOR_CYCLES = qrw_pkg::SECTOR_ERASE_CYCLES,
	parameter int unsigned HALF_CYCLES = qrw_pkg::HALF_BLOCK_ERASE_CYCLES,
	parameter int unsigned BLOCK_CYCLES = qrw_pkg::BLOCK_ERASE_CYCLES,
	parameter int unsigned CHIP_CYCLES = qrw_pkg::WHOLE_ARRAY_ERASE_CYCLES
) (
	// System
	input wire logic clk,
	input wire logic sys_rst,
	// Link
	qrw_link_if.dev link,
	// Status inputs
	input wire logic quadEnable,
	input wire logic [4:0] blockProtect,
	// Status outputs
	output logic writeInProgress,
	output logic writeEnableLatch,
	output logic contMode,
	output logic [2:0] wrapSetting,
	output logic [23:0] eraseBase
);
	import qrw_pkg::*;

	logic [5:0] syncA_r, syncB_r, syncC_r;
	logic [3:0] ioS;
	logic csHigh, sclkRise, sclkFall, csRise, csFall, nibLow_r;
	qrw_dev_state_t state_r;
	logic [5:0] cnt_r;
	logic [31:0] sh_r, eraseCnt_r, eraseLen;
	logic [7:0] opc_r, mode_r, opcIn;
	logic [ADDR_W-1:0] addr_r, addr_nxt, wrapMask, addrIn;
	logic [7:0] mem_r [MEM_BYTES];
	logic cmdOk, wrenHit, chipHit, addrHit, wrapHit, protAny;
	logic startErase, dropLatch, eraseDone;

	// Two-stage synchronisers for all link pins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			syncA_r <= SYNC_IDLE;
			syncB_r <= SYNC_IDLE;
			syncC_r <= SYNC_IDLE;
		end else begin
			syncA_r <= {link.csN, link.sclk, link.io};
			syncB_r <= syncA_r;
			syncC_r <= syncB_r;
		end
	end

	assign csHigh = syncB_r[5];
	assign ioS = syncB_r[3:0];
	assign sclkRise = syncB_r[4] & ~syncC_r[4] & ~csHigh;
	assign sclkFall = ~syncB_r[4] & syncC_r[4] & ~csHigh;
	assign csRise = csHigh & ~syncC_r[5];
	assign csFall = ~csHigh & syncC_r[5];
	assign opcIn = {sh_r[6:0], ioS[0]};
	assign addrIn = {sh_r[15:0], ioS};

	// Burst wrap keeps the upper address bits inside the section
	always_comb begin
		wrapMask = (ADDR_W'(8) << wrapSetting[2:1]) - ADDR_W'(1);
		if (wrapSetting[0]) begin
			addr_nxt = addr_r + ADDR_W'(1);
		end else begin
			addr_nxt = (addr_r & ~wrapMask) |
				((addr_r + ADDR_W'(1)) & wrapMask);
		end
	end

	// Command decode at chip select rise
	always_comb begin
		protAny = blockProtect != 5'h00;
		cmdOk = csRise && state_r == DS_SER && !writeInProgress;
		wrenHit = cmdOk && opc_r == OPC_WRITE_ENABLE &&
			cnt_r == BITS_SHORT;
		chipHit = cmdOk && writeEnableLatch && cnt_r == BITS_SHORT &&
			(opc_r == OPC_CHIP_ERASE_A ||
			opc_r == OPC_CHIP_ERASE_B);
		addrHit = cmdOk && writeEnableLatch && cnt_r == BITS_ADDR &&
			(opc_r == OPC_PAGE_ERASE || opc_r == OPC_SECTOR_ERASE ||
			opc_r == OPC_HALF_BLOCK_ERASE ||
			opc_r == OPC_BLOCK_ERASE);
		wrapHit = cmdOk && opc_r == OPC_SET_WRAP &&
			cnt_r == BITS_WRAP;
		startErase = (chipHit || addrHit) && !protAny;
		dropLatch = addrHit && protAny &&
			opc_r == OPC_HALF_BLOCK_ERASE;
		eraseDone = writeInProgress && eraseCnt_r == 32'h1;
		case (opc_r)
			OPC_PAGE_ERASE: eraseLen = 32'(PAGE_CYCLES);
			OPC_SECTOR_ERASE: eraseLen = 32'(SECTOR_CYCLES);
			OPC_HALF_BLOCK_ERASE: eraseLen = 32'(HALF_CYCLES);
			OPC_BLOCK_ERASE: eraseLen = 32'(BLOCK_CYCLES);
			default: eraseLen = 32'(CHIP_CYCLES);
		endcase
	end

	// Self-timed erase and the write enable latch
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			writeInProgress <= 1'b0;
			writeEnableLatch <= 1'b0;
			eraseCnt_r <= 32'h0;
		end else begin
			if (startErase) begin
				writeInProgress <= 1'b1;
				eraseCnt_r <= eraseLen;
			end else if (eraseDone) begin
				writeInProgress <= 1'b0;
				writeEnableLatch <= 1'b0;
			end else if (writeInProgress) begin
				eraseCnt_r <= eraseCnt_r - 32'h1;
			end
			if (wrenHit) begin
				writeEnableLatch <= 1'b1;
			end
			if (dropLatch) begin
				writeEnableLatch <= 1'b0;
			end
		end
	end

	// Erased region base, aligned to the erase unit
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			eraseBase <= 24'h0;
		end else if (startErase) begin
			case (opc_r)
				OPC_PAGE_ERASE: eraseBase <= {sh_r[23:8], 8'h00};
				OPC_SECTOR_ERASE: eraseBase <= {sh_r[23:12], 12'h000};
				OPC_HALF_BLOCK_ERASE: eraseBase <= {sh_r[23:15], 15'h0};
				OPC_BLOCK_ERASE: eraseBase <= {sh_r[23:16], 16'h0};
				default: eraseBase <= 24'h0;
			endcase
		end
	end

	// Array window, mirrored across the address space
	genvar gi;
	generate
		for (gi = 0; gi < MEM_BYTES; gi++) begin : gMem
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					mem_r[gi] <= MEM_RESET ^ 8'(gi);
				end else if (eraseDone) begin
					mem_r[gi] <= MEM_ERASED;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wrapSetting <= WRAP_RESET;
		end else if (wrapHit) begin
			wrapSetting <= sh_r[6:4];
		end
	end

	// Link protocol engine
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= DS_IDLE;
			cnt_r <= 6'h0;
			sh_r <= 32'h0;
			opc_r <= 8'h0;
			mode_r <= 8'h0;
			addr_r <= '0;
			nibLow_r <= 1'b0;
			contMode <= 1'b0;
			link.devIo <= 4'hF;
			link.devIoOeN <= 4'hF;
		end else if (csRise) begin
			state_r <= DS_IDLE;
			link.devIoOeN <= 4'hF;
			// Mode only persists once the mode byte was taken
			contMode <= (state_r == DS_QDUMMY || state_r == DS_QDATA) &&
				mode_r[5:4] == CONT_MODE_KEY;
		end else if (csFall) begin
			state_r <= contMode ? DS_QADDR : DS_OPC;
			cnt_r <= 6'h0;
			nibLow_r <= 1'b0;
		end else if (sclkRise) begin
			case (state_r)
				DS_OPC: begin
					sh_r <= {sh_r[30:0], ioS[0]};
					cnt_r <= cnt_r + 6'h1;
					if (cnt_r == OPC_LAST) begin
						opc_r <= opcIn;
						if (opcIn != OPC_QUAD_IO_READ) begin
							state_r <= DS_SER;
						end else if (writeInProgress || !quadEnable) begin
							state_r <= DS_SKIP;
						end else begin
							state_r <= DS_QADDR;
							cnt_r <= 6'h0;
						end
					end
				end
				DS_QADDR: begin
					sh_r <= {sh_r[27:0], ioS};
					cnt_r <= cnt_r + 6'h1;
					if (cnt_r == QADDR_LAST) begin
						addr_r <= addrIn;
						state_r <= DS_QMODE;
						cnt_r <= 6'h0;
					end
				end
				DS_QMODE: begin
					sh_r <= {sh_r[27:0], ioS};
					cnt_r <= cnt_r + 6'h1;
					if (cnt_r == QMODE_LAST) begin
						mode_r <= {sh_r[3:0], ioS};
						state_r <= DS_QDUMMY;
						cnt_r <= 6'h0;
					end
				end
				DS_QDUMMY: begin
					cnt_r <= cnt_r + 6'h1;
					if (cnt_r == QDUMMY_LAST) begin
						state_r <= DS_QDATA;
					end
				end
				DS_SER: begin
					sh_r <= {sh_r[30:0], ioS[0]};
					if (cnt_r != 6'h3F) begin
						cnt_r <= cnt_r + 6'h1;
					end
				end
				default: begin
				end
			endcase
		end else if (sclkFall && state_r == DS_QDATA) begin
			link.devIoOeN <= 4'h0;
			nibLow_r <= ~nibLow_r;
			if (!nibLow_r) begin
				link.devIo <= mem_r[addr_r[MEM_IDX_W-1:0]][7:4];
			end else begin
				link.devIo <= mem_r[addr_r[MEM_IDX_W-1:0]][3:0];
				addr_r <= addr_nxt;
			end
		end
	end
endmodule // qrw_flash_dev

// ---- bench/qrw_properties.sv ----
`timescale 1ns/1ps
module qrw_properties (
	// System
	input wire logic clk,
	input wire logic sys_rst,
	// Link
	input wire logic csN,
	input wire logic sclk,
	input wire logic [3:0] hostIoOeN,
	input wire logic [3:0] devIo,
	input wire logic [3:0] devIoOeN,
	// Device status
	input wire logic writeInProgress,
	input wire logic writeEnableLatch
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_sclk_idle: assert property (csN && $past(csN, 2) |-> !sclk)
		else $error("serial clock moves while deselected");
	a_dev_released: assert property (csN && $past(csN, 4) |-> &devIoOeN)
		else $error("device drives lanes while deselected");
	a_lane_clash: assert property (&(hostIoOeN | devIoOeN))
		else $error("both ends drive one lane");
	a_busy_silent: assert property (writeInProgress |-> &devIoOeN)
		else $error("device answers a read while busy");
	a_data_steady: assert property ($rose(sclk) && devIoOeN == 4'h0 |->
		$stable(devIo) ##1 $stable(devIo))
		else $error("read nibble changes near rising edge");
	a_start_latched: assert property ($rose(writeInProgress) |->
		$past(writeEnableLatch))
		else $error("erase started without latch");
	a_start_on_cs: assert property ($rose(writeInProgress) |->
		csN && $past(csN))
		else $error("erase started while selected");
	a_busy_min: assert property ($rose(writeInProgress) |->
		writeInProgress[*8])
		else $error("erase cycle too short");
	a_latch_drop: assert property ($fell(writeInProgress) |->
		##[0:1] !writeEnableLatch)
		else $error("latch kept after erase");

	c_erase_done: cover property ($fell(writeInProgress));
	c_read_data: cover property ($rose(sclk) && devIoOeN == 4'h0);
	c_quad_addr: cover property (!csN && hostIoOeN == 4'h0);
endmodule // qrw_properties

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
	import qrw_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, junk;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic quadEnable = 1'b1;
	logic [4:0] blockProtect = 5'h00;
	logic write_in_progress, write_enable_latch, contMode;
	logic [2:0] wrapSetting;
	logic [23:0] eraseBase;
	logic [65:0] rQ[$];
	logic [1:0] bQ[$];
	logic [65:0] note;
	logic [3:0] wstrb = 4'hF;
	logic [19:0] a;
	logic [31:0] a32;
	logic [7:0] opcs[6] = '{OPC_PAGE_ERASE, OPC_SECTOR_ERASE,
		OPC_HALF_BLOCK_ERASE, OPC_BLOCK_ERASE, OPC_CHIP_ERASE_A,
		OPC_CHIP_ERASE_B};
	logic [23:0] msks[6] = '{24'hFFFF00, 24'hFFF000, 24'hFF8000,
		24'hFF0000, 24'h000000, 24'h000000};
	logic [2:0] nbs[6] = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h0, 3'h0};
	int errCount = 0;
	int checks = 0;

	always #4 clk = ~clk;

	qrw_link_if link();
	qrw_flash_host qrw_flash_host_inst(.clk(clk), .sys_rst(sys_rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .link(link.host));
	qrw_flash_dev #(.PAGE_CYCLES(3000), .SECTOR_CYCLES(200),
		.HALF_CYCLES(200), .BLOCK_CYCLES(200), .CHIP_CYCLES(200))
		qrw_flash_dev_inst(.clk(clk), .sys_rst(sys_rst), .link(link.dev),
		.quadEnable(quadEnable), .blockProtect(blockProtect),
		.writeInProgress(write_in_progress), .writeEnableLatch(write_enable_latch), .contMode(contMode),
		.wrapSetting(wrapSetting), .eraseBase(eraseBase));
	qrw_properties qrw_properties_inst(.clk(clk), .sys_rst(sys_rst),
		.csN(link.csN), .sclk(link.sclk), .hostIoOeN(link.hostIoOeN),
		.devIo(link.devIo), .devIoOeN(link.devIoOeN),
		.writeInProgress(write_in_progress), .writeEnableLatch(write_enable_latch));

	task automatic check(input string name, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			errCount++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic giveVerdict();
		$display("Checks %0d, errors %0d", checks, errCount);
		if (errCount == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [4:0] ad, input logic [31:0] d,
		input logic [1:0] er);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge clk);
		awaddr <= {27'h0, ad};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		bQ.push_back(er);
		do begin
			@(posedge clk);
			if (aw && awready === 1'b1) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end while (aw || w);
		do begin
			@(posedge clk);
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] ad, input logic [31:0] m, e,
		output logic [31:0] d);
		@(posedge clk);
		araddr <= {27'h0, ad};
		arvalid <= 1'b1;
		rready <= 1'b1;
		rQ.push_back({ad > REG_STATUS ? RESP_SLVERR : RESP_OKAY, m, e});
		do begin
			@(posedge clk);
		end while (arready !== 1'b1);
		arvalid <= 1'b0;
		do begin
			@(posedge clk);
		end while (rvalid !== 1'b1);
		d = rdata;
		rready <= 1'b0;
	endtask

	task automatic frame(input logic [20:0] cmd, input logic [31:0] tx);
		logic [31:0] s;
		wr(REG_TX, tx, RESP_OKAY);
		wr(REG_CMD, {11'h0, cmd}, RESP_OKAY);
		do begin
			rd(REG_STATUS, 32'hFFFFFFFE, 32'h0, s);
		end while (s[0] !== 1'b0);
	endtask

	task automatic waitIdle();
		while (write_in_progress !== 1'b0) begin
			@(posedge clk);
		end
	endtask

	// Serial frames wait out any erase so the write enable is not lost
	task automatic ser(input logic [7:0] op, input logic [2:0] nb,
		input logic [31:0] tx);
		waitIdle();
		frame({8'h0, nb, 2'b00, op}, tx);
	endtask

	task automatic qread(input logic [19:0] ad, input logic [7:0] md,
		input logic skip, input logic [31:0] e);
		frame({8'h04, 3'h0, skip, 1'b1, OPC_QUAD_IO_READ}, {4'h0, ad, md});
		rd(REG_RX, 32'hFFFFFFFF, e, junk);
	endtask

	// Window byte equals its index; wrap keeps the aligned section
	function automatic logic [31:0] exp4(input logic [19:0] ad,
		input int len);
		logic [31:0] r;
		logic [5:0] m;
		m = 6'(len - 1);
		r = 32'h0;
		for (int k = 0; k < 4; k++)
			r = {r[23:0], 2'b00, (ad[5:0] & ~m) | (6'(ad + k) & m)};
		return r;
	endfunction

	always @(posedge clk) begin
		if (rvalid === 1'b1 && rready === 1'b1 && rQ.size() > 0) begin
			note = rQ.pop_front();
			check("read data", note[31:0], rdata & note[63:32]);
			check("read response", {30'h0, note[65:64]}, {30'h0, rresp});
		end
		if (bvalid === 1'b1 && bready === 1'b1 && bQ.size() > 0)
			check("write response", {30'h0, bQ.pop_front()}, {30'h0, bresp});
	end

	initial begin
		repeat (80000) @(posedge clk);
		errCount++;
		giveVerdict();
	end

	initial begin
		void'($urandom(67749));
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		check("wrap", 32'h7, {29'h0, wrapSetting});
		wr(5'h10, 32'h0, RESP_SLVERR);
		rd(5'h14, 32'hFFFFFFFF, 32'h0, junk);
		a32 = $urandom;
		wr(REG_TX, a32, RESP_OKAY);
		wstrb <= 4'h5;
		wr(REG_TX, ~a32, RESP_OKAY);
		wstrb <= 4'hF;
		rd(REG_TX, 32'hFFFFFFFF, {a32[31:24], ~a32[23:16], a32[15:8],
			~a32[7:0]}, junk);
		qread(20'hFFFFE, 8'h00, 1'b0, 32'h3E3F0001);
		check("cont", 32'h0, {31'h0, contMode});
		a = 20'($urandom);
		qread(a, 8'h20 | 8'($urandom & 32'hCF), 1'b0, exp4(a, 64));
		check("cont", 32'h1, {31'h0, contMode});
		a = 20'($urandom);
		qread(a, 8'h00, 1'b1, exp4(a, 64));
		check("cont", 32'h0, {31'h0, contMode});
		qread(a, 8'h20, 1'b0, exp4(a, 64));
		ser(8'hFF, 3'h0, 32'h0);
		check("cont", 32'h0, {31'h0, contMode});
		for (int w = 0; w < 4; w++) begin
			ser(OPC_SET_WRAP, 3'h4, {25'h0, 2'(w), 5'h00});
			check("wrap", {29'h0, 2'(w), 1'b0}, {29'h0, wrapSetting});
			a = (20'($urandom) & 20'hFFFC0) | 20'((8 << w) - 2);
			qread(a, 8'h00, 1'b0, exp4(a, 8 << w));
		end
		ser(OPC_SET_WRAP, 3'h4, 32'h70);
		check("wrap", 32'h7, {29'h0, wrapSetting});
		qread(20'h6, 8'h00, 1'b0, 32'h06070809);
		quadEnable <= 1'b0;
		qread(20'h6, 8'h00, 1'b0, 32'hFFFFFFFF);
		quadEnable <= 1'b1;
		blockProtect <= 5'(1 + $urandom % 31);
		ser(OPC_WRITE_ENABLE, 3'h0, 32'h0);
		check("latch", 32'h1, {31'h0, write_enable_latch});
		ser(OPC_BLOCK_ERASE, 3'h3, $urandom);
		check("busy", 32'h0, {31'h0, write_in_progress});
		ser(OPC_HALF_BLOCK_ERASE, 3'h3, $urandom);
		check("latch", 32'h0, {31'h0, write_enable_latch});
		ser(OPC_WRITE_ENABLE, 3'h0, 32'h0);
		ser(OPC_CHIP_ERASE_B, 3'h0, 32'h0);
		check("busy", 32'h0, {31'h0, write_in_progress});
		blockProtect <= 5'h00;
		ser(OPC_SECTOR_ERASE, 3'h2, $urandom);
		check("busy", 32'h0, {31'h0, write_in_progress});
		qread(20'h0, 8'h00, 1'b0, 32'h00010203);
		for (int i = 0; i < 6; i++) begin
			ser(OPC_WRITE_ENABLE, 3'h0, 32'h0);
			a32 = $urandom;
			ser(opcs[i], nbs[i], a32);
			check("busy", 32'h1, {31'h0, write_in_progress});
			check("base", {8'h0, a32[31:8] & msks[i]}, {8'h0, eraseBase});
			if (i == 0) begin
				qread(20'h5, 8'h00, 1'b0, 32'hFFFFFFFF);
				check("busy", 32'h1, {31'h0, write_in_progress});
			end
			waitIdle();
			check("latch", 32'h0, {31'h0, write_enable_latch});
		end
		qread(20'h9, 8'h00, 1'b0, 32'hFFFFFFFF);
		giveVerdict();
	end
endmodule // tb
